// >>> inc/config_bank_defs.vh
// Constants for the configuration register bank and second clock path.
// Register offsets are word indices; the APB byte address is index * 4.
`ifndef CONFIG_BANK_DEFS_VH
`define CONFIG_BANK_DEFS_VH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define IDX_BANK_SEL      8'h00
`define IDX_BANK_SRC_A    8'h07
`define IDX_BANK_SRC_B    8'h08
`define IDX_PIN_FUNC_1    8'h0B
`define IDX_PIN_FUNC_2    8'h0C
`define IDX_PIN_SRC_0     8'h0D
`define IDX_PIN_SRC_3     8'h10
`define IDX_PIN_STATUS    8'h41
`define IDX_INT_STATUS    8'h42
`define IDX_GLOBAL_STAT   8'h43
`define IDX_P2_STATUS     8'h49
`define IDX_P2_CTRL_A     8'h60
`define IDX_P2_CTRL_C     8'h62
`define IDX_FB_FIRST      8'h70
`define IDX_FB_LAST       8'h75
`define IDX_FB_LOAD       8'h76
`define IDX_FRAC_FIRST    8'h78
`define IDX_FRAC_LAST     8'h7C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BANK_SEL_BIT      7
`define BOOT_DONE_BIT     7
`define INT_ENABLE_BIT    1
`define INT_STATE_BIT     0
`define SWITCH_EN_BIT     7
`define ALT_SEL_MSB       5
`define ALT_SEL_LSB       3
`define PRI_SEL_MSB       2
`define PRI_SEL_LSB       0
`define READ_LIVE_BIT     0

// ----------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------
`define BYTE_ZERO         8'h00
`define WORD_ZERO         32'h0000_0000
`define BANK_SRC_MASK     8'h3F
`define P2_CTRL_A_MASK    8'h03
`define P2_CTRL_C_MASK    8'hBF
`define GLOBAL_IE_MASK    8'h0F
`define INT_STAT_MASK     8'h02
`define FB_LAST_MASK      8'h03
`define LOAD_MASK         8'h01
`define FB_RESET          42'h000_0000_0000
`define FRAC_RESET        40'h00_0000_0000

// ----------------------------------------------------------------------
// Straps, selector codes and bank source codes
// ----------------------------------------------------------------------
`define TEST_STRAP_MATCH  1'b1
`define CFG_STRAP_MATCH   3'h0
`define IF_STRAP_MATCH    2'h3
`define REF_INPUT_1       3'h0
`define REF_INPUT_2       3'h1
`define REF_INPUT_3       3'h2
`define REF_XTAL_PIN      3'h3
`define REF_XTAL_DRIVER   3'h4
`define SRC_PLL_INT       2'h0
`define SRC_PLL_FRAC      2'h1
`define SRC_PATH2         2'h2
// Reset pin bit starts at its idle high level: no false rise after reset
`define SYNC_RESET        11'h400
// Byte number in a multi-byte field comes from the low index bits
`define FB_BYTE_BASE      3'h0
`define FRAC_BYTE_BASE    3'h0

`endif

// >>> hdl/config_register_bank_path2_select.v
// Configuration register bank with strapped memory-write mode, second
// clock path input selector and output bank source selection.
// Assumes an APB master on clk, pins sampled through synchronisers and
// an external nonvolatile memory port answering reads combinationally.
//
// Function
// - Straps at reset release enter memory-write mode
// - Memory-write mode maps memory, hides registers
// - Next reset release leaves memory-write mode
// - Serial data output driven throughout memory-write mode
// - Second path selects inputs, crystal pin, driver
// - Bank source field picks integer, fraction, path
// - Switch disabled: primary field drives selector
// - Switch enabled: pin low primary, high alternate
// - Switch pin field chooses controlling pin
// - Status field shows selected second path reference
// - Byte registers; undefined addresses are reserved
// - Read-only fields ignore writes; others read-write
// - Real-time bits return live level
// - Latched bits set on edge, clear on one
// - Latched bit requests interrupt only when enabled
// - Reset returns configuration to defaults
// - Multi-byte writes ascend through transfer register
// - Last byte updates whole field at once
// - Multi-byte reads return stored value
// - Read-live bit returns live feedback divider
// - Bank select maps memory above address zero
`include "config_bank_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module config_register_bank_path2_select
(
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        resetPinLow,
  input  wire        testStrap,
  input  wire [2:0]  configSelectStraps,
  input  wire [1:0]  ifaceSelectStraps,
  input  wire [3:0]  gpioPin,
  input  wire        bootDoneFlag,
  input  wire [41:0] feedbackDividerLive,
  input  wire        serialOutReq,
  output wire        serialOutEn,
  output wire        directWriteMode,
  output wire        nvmWrStb,
  output wire [7:0]  nvmAddr,
  output wire [7:0]  nvmWrData,
  input  wire [7:0]  nvmRdData,
  input  wire        inputClockOne,
  input  wire        inputClockTwo,
  input  wire        inputClockThree,
  input  wire        crystalPinIn,
  input  wire        crystalDriverClk,
  input  wire        pllIntClk,
  input  wire        pllFracClk,
  output wire        path2Clk,
  output wire [2:0]  selectedReference,
  output wire [5:0]  bankClk,
  output wire [11:0] bankSourceSelect,
  output wire [41:0] feedbackDividerField,
  output wire [39:0] fractionalDividerField,
  output wire [7:0]  pinFunctionReg,
  output wire        interruptReq
);

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  reg  [10:0] syncA_r;
  reg  [10:0] syncB_r;
  reg         rstPinPrev_r;
  reg  [3:0]  gpioPrev_r;
  wire        rstPinSync;
  wire        testSync;
  wire [2:0]  cfgSync;
  wire [1:0]  ifSync;
  wire [3:0]  gpioSync;
  wire        rstPinRise;
  wire        strapMatch;
  wire        cfgRst;

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      syncA_r      <= `SYNC_RESET;
      syncB_r      <= `SYNC_RESET;
      rstPinPrev_r <= 1'b1;
      gpioPrev_r   <= 4'h0;
    end
    else
    begin
      syncA_r      <= {resetPinLow, testStrap, configSelectStraps,
                       ifaceSelectStraps, gpioPin};
      syncB_r      <= syncA_r;
      rstPinPrev_r <= rstPinSync;
      gpioPrev_r   <= gpioSync;
    end
  end

  assign rstPinSync = syncB_r[10];
  assign testSync   = syncB_r[9];
  assign cfgSync    = syncB_r[8:6];
  assign ifSync     = syncB_r[5:4];
  assign gpioSync   = syncB_r[3:0];
  assign rstPinRise = rstPinSync & ~rstPinPrev_r;
  assign strapMatch = (testSync == `TEST_STRAP_MATCH) &
                      (cfgSync == `CFG_STRAP_MATCH) &
                      (ifSync == `IF_STRAP_MATCH);
  // Configuration held at defaults while the reset pin is low
  assign cfgRst     = sys_rst | ~rstPinSync;

  // --------------------------------------------------------------------
  // Memory-write mode
  // --------------------------------------------------------------------
  reg directMode_r;

  always @(posedge clk)
  begin
    if (sys_rst)
      directMode_r <= 1'b0;
    else if (rstPinRise)
      directMode_r <= ~directMode_r & strapMatch;
  end

  assign directWriteMode = directMode_r;
  assign serialOutEn     = directMode_r | serialOutReq;

  // --------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------
  reg  [7:0]  bankSel_r;
  wire [7:0]  idx;
  wire        aligned;
  wire        memBank;
  wire        setup;
  wire        access;
  wire        regWr;
  reg         mapped;

  assign idx     = paddr[9:2];
  assign aligned = (paddr[31:10] == 22'h0) & (paddr[1:0] == 2'h0);
  assign memBank = directMode_r |
                   (bankSel_r[`BANK_SEL_BIT] &
                    (idx != `IDX_BANK_SEL));
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign regWr   = access & pwrite & aligned & mapped & ~memBank;
  assign pready  = 1'b1;
  assign pslverr = access & ~(aligned & (mapped | memBank));

  always @*
  begin
    mapped = 1'b1;
    case (idx)
      `IDX_BANK_SEL, `IDX_BANK_SRC_A, `IDX_BANK_SRC_B,
      `IDX_PIN_FUNC_1, `IDX_PIN_FUNC_2, `IDX_PIN_STATUS,
      `IDX_INT_STATUS, `IDX_GLOBAL_STAT, `IDX_P2_STATUS,
      `IDX_P2_CTRL_A, `IDX_P2_CTRL_C, `IDX_FB_LOAD:
        mapped = 1'b1;
      default:
        mapped = ((idx >= `IDX_PIN_SRC_0) & (idx <= `IDX_PIN_SRC_3)) |
                 ((idx >= `IDX_FB_FIRST) & (idx <= `IDX_FB_LAST)) |
                 ((idx >= `IDX_FRAC_FIRST) & (idx <= `IDX_FRAC_LAST));
    endcase
  end

  // --------------------------------------------------------------------
  // Nonvolatile memory port
  // --------------------------------------------------------------------
  reg       nvmStb_r;
  reg [7:0] nvmAddr_r;
  reg [7:0] nvmData_r;

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      nvmStb_r  <= 1'b0;
      nvmAddr_r <= `BYTE_ZERO;
      nvmData_r <= `BYTE_ZERO;
    end
    else
    begin
      nvmStb_r <= access & pwrite & aligned & memBank;
      if (access & pwrite & aligned & memBank)
      begin
        nvmAddr_r <= idx;
        nvmData_r <= pwdata[7:0];
      end
    end
  end

  assign nvmWrStb  = nvmStb_r;
  assign nvmAddr   = nvmAddr_r;
  assign nvmWrData = nvmData_r;

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  reg [7:0]  bankSrcA_r;
  reg [7:0]  bankSrcB_r;
  reg [7:0]  pinFunc1_r;
  reg [7:0]  pinFunc2_r;
  reg [7:0]  pinSrc_r [0:3];
  reg [7:0]  globalIe_r;
  reg [7:0]  intCtl_r;
  reg [7:0]  p2CtrlA_r;
  reg [7:0]  p2CtrlC_r;
  reg [7:0]  fbLoad_r;
  reg [39:0] fbXfer_r;
  reg [31:0] fracXfer_r;
  reg [41:0] fbDiv_r;
  reg [39:0] fracDiv_r;
  wire [2:0] fbByte;
  wire [2:0] fracByte;
  integer    i;

  assign fbByte   = idx[2:0] - `FB_BYTE_BASE;
  assign fracByte = idx[2:0] - `FRAC_BYTE_BASE;

  always @(posedge clk)
  begin
    if (cfgRst)
    begin
      bankSel_r  <= `BYTE_ZERO;
      bankSrcA_r <= `BYTE_ZERO;
      bankSrcB_r <= `BYTE_ZERO;
      pinFunc1_r <= `BYTE_ZERO;
      pinFunc2_r <= `BYTE_ZERO;
      for (i = 0; i < 4; i = i + 1)
        pinSrc_r[i] <= `BYTE_ZERO;
      globalIe_r <= `BYTE_ZERO;
      intCtl_r   <= `BYTE_ZERO;
      p2CtrlA_r  <= `BYTE_ZERO;
      p2CtrlC_r  <= `BYTE_ZERO;
      fbLoad_r   <= `BYTE_ZERO;
      fbXfer_r   <= 40'h00_0000_0000;
      fracXfer_r <= `WORD_ZERO;
      fbDiv_r    <= `FB_RESET;
      fracDiv_r  <= `FRAC_RESET;
    end
    else if (regWr)
    begin
      // Reserved and read-only bits are masked off on write
      case (idx)
        `IDX_BANK_SEL:    bankSel_r  <= pwdata[7:0] & 8'h80;
        `IDX_BANK_SRC_A:  bankSrcA_r <= pwdata[7:0] & `BANK_SRC_MASK;
        `IDX_BANK_SRC_B:  bankSrcB_r <= pwdata[7:0] & `BANK_SRC_MASK;
        `IDX_PIN_FUNC_1:  pinFunc1_r <= pwdata[7:0];
        `IDX_PIN_FUNC_2:  pinFunc2_r <= pwdata[7:0];
        `IDX_GLOBAL_STAT: globalIe_r <= pwdata[7:0] & `GLOBAL_IE_MASK;
        `IDX_INT_STATUS:  intCtl_r   <= pwdata[7:0] & `INT_STAT_MASK;
        `IDX_P2_CTRL_A:   p2CtrlA_r  <= pwdata[7:0] & `P2_CTRL_A_MASK;
        `IDX_P2_CTRL_C:   p2CtrlC_r  <= pwdata[7:0] & `P2_CTRL_C_MASK;
        `IDX_FB_LOAD:     fbLoad_r   <= pwdata[7:0] & `LOAD_MASK;
        `IDX_FB_LAST:     fbDiv_r    <= {pwdata[1:0], fbXfer_r};
        `IDX_FRAC_LAST:   fracDiv_r  <= {pwdata[7:0], fracXfer_r};
        default:
        begin
          if ((idx >= `IDX_PIN_SRC_0) & (idx <= `IDX_PIN_SRC_3))
            pinSrc_r[idx[1:0] - 2'h1] <= pwdata[7:0];
          else if ((idx >= `IDX_FRAC_FIRST) & (idx <= `IDX_FRAC_LAST))
            fracXfer_r[8*fracByte +: 8] <= pwdata[7:0];
          else if ((idx >= `IDX_FB_FIRST) & (idx <= `IDX_FB_LAST))
            fbXfer_r[8*fbByte +: 8] <= pwdata[7:0];
        end
      endcase
    end
  end

  assign bankSourceSelect       = {bankSrcB_r[5:0], bankSrcA_r[5:0]};
  assign feedbackDividerField   = fbDiv_r;
  assign fractionalDividerField = fracDiv_r;
  assign pinFunctionReg         = pinFunc1_r;

  // --------------------------------------------------------------------
  // Latched pin status and interrupt
  // --------------------------------------------------------------------
  reg  [3:0] gpioLatch_r;
  wire [3:0] gpioEdge;
  wire       intState;

  assign gpioEdge = gpioSync ^ gpioPrev_r;

  always @(posedge clk)
  begin
    if (cfgRst)
      gpioLatch_r <= 4'h0;
    else if (regWr & (idx == `IDX_PIN_STATUS))
      // A new edge wins over a simultaneous clear
      gpioLatch_r <= (gpioLatch_r & ~pwdata[7:4]) | gpioEdge;
    else
      gpioLatch_r <= gpioLatch_r | gpioEdge;
  end

  assign intState     = |(gpioLatch_r & globalIe_r[3:0]);
  assign interruptReq = intState & intCtl_r[`INT_ENABLE_BIT];

  // --------------------------------------------------------------------
  // Second path input selector
  // --------------------------------------------------------------------
  wire       switchPin;
  reg  [2:0] refSel;
  reg        p2Mux;

  assign switchPin = gpioSync[p2CtrlA_r[1:0]];

  always @*
  begin
    if (p2CtrlC_r[`SWITCH_EN_BIT] & switchPin)
      refSel = p2CtrlC_r[`ALT_SEL_MSB:`ALT_SEL_LSB];
    else
      refSel = p2CtrlC_r[`PRI_SEL_MSB:`PRI_SEL_LSB];
  end

  always @*
  begin
    case (refSel)
      `REF_INPUT_1:     p2Mux = inputClockOne;
      `REF_INPUT_2:     p2Mux = inputClockTwo;
      `REF_INPUT_3:     p2Mux = inputClockThree;
      `REF_XTAL_PIN:    p2Mux = crystalPinIn;
      `REF_XTAL_DRIVER: p2Mux = crystalDriverClk;
      default:          p2Mux = 1'b0;
    endcase
  end

  assign path2Clk          = p2Mux;
  assign selectedReference = refSel;

  // --------------------------------------------------------------------
  // Output bank source muxes
  // --------------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < 6; b = b + 1)
    begin : bankMux
      wire [1:0] src;
      assign src = bankSourceSelect[2*b +: 2];
      assign bankClk[b] = (src == `SRC_PLL_INT)  ? pllIntClk :
                          (src == `SRC_PLL_FRAC) ? pllFracClk :
                          (src == `SRC_PATH2)    ? p2Mux : 1'b0;
    end
  endgenerate

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  reg  [7:0]  rdByte;
  reg  [31:0] prdata_r;
  wire [47:0] fbRead;
  wire [39:0] fracRead;

  assign fbRead   = {6'h00, fbLoad_r[`READ_LIVE_BIT] ?
                            feedbackDividerLive : fbDiv_r};
  assign fracRead = fracDiv_r;

  always @*
  begin
    rdByte = `BYTE_ZERO;
    case (idx)
      `IDX_BANK_SEL:    rdByte = bankSel_r;
      `IDX_BANK_SRC_A:  rdByte = bankSrcA_r;
      `IDX_BANK_SRC_B:  rdByte = bankSrcB_r;
      `IDX_PIN_FUNC_1:  rdByte = pinFunc1_r;
      `IDX_PIN_FUNC_2:  rdByte = pinFunc2_r;
      `IDX_PIN_STATUS:  rdByte = {gpioLatch_r, gpioSync};
      `IDX_INT_STATUS:  rdByte = {6'h00, intCtl_r[`INT_ENABLE_BIT],
                                 intState};
      `IDX_GLOBAL_STAT: rdByte = {bootDoneFlag, 3'h0, globalIe_r[3:0]};
      `IDX_P2_STATUS:   rdByte = {5'h00, refSel};
      `IDX_P2_CTRL_A:   rdByte = p2CtrlA_r;
      `IDX_P2_CTRL_C:   rdByte = p2CtrlC_r;
      `IDX_FB_LOAD:     rdByte = fbLoad_r;
      default:
      begin
        if ((idx >= `IDX_PIN_SRC_0) & (idx <= `IDX_PIN_SRC_3))
          rdByte = pinSrc_r[idx[1:0] - 2'h1];
        else if ((idx >= `IDX_FRAC_FIRST) & (idx <= `IDX_FRAC_LAST))
          rdByte = fracRead[8*fracByte +: 8];
        else if ((idx >= `IDX_FB_FIRST) & (idx <= `IDX_FB_LAST))
          rdByte = fbRead[8*fbByte +: 8];
      end
    endcase
  end

  always @(posedge clk)
  begin
    if (sys_rst)
      prdata_r <= `WORD_ZERO;
    else if (setup & ~pwrite)
    begin
      if (~aligned)
        prdata_r <= `WORD_ZERO;
      else if (memBank)
        prdata_r <= {24'h000000, nvmRdData};
      else
        prdata_r <= {24'h000000, rdByte};
    end
  end

  assign prdata = prdata_r;

endmodule

`default_nettype wire

// >>> bench/nvm_model.sv
// Nonvolatile memory seen through the bank's memory port.
// Assumes reads are indexed by the APB word index, writes by strobe.
`timescale 1ns/1ps
`default_nettype none

module nvm_model
(
  input  wire logic       clk,
  input  wire logic       wrStb,
  input  wire logic [7:0] wrAddr,
  input  wire logic [7:0] wrData,
  input  wire logic [7:0] rdIdx,
  output wire logic [7:0] rdData
);
  logic [7:0] mem [0:255];

  always @(posedge clk)
    if (wrStb)
      mem[wrAddr] <= wrData;

  assign rdData = mem[rdIdx];
endmodule

`default_nettype wire

// >>> bench/config_bank_checker.sv
// Port-level assertions for the configuration register bank.
// Assumes one clock and the synchronous active-high reset.
`include "config_bank_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module config_bank_checker
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        resetPinLow,
  input wire logic        serialOutEn,
  input wire logic        directWriteMode,
  input wire logic        nvmWrStb,
  input wire logic        pllFracClk,
  input wire logic        path2Clk,
  input wire logic [5:0]  bankClk,
  input wire logic [11:0] bankSourceSelect,
  input wire logic [41:0] feedbackDividerField,
  input wire logic [39:0] fractionalDividerField
);
  wire       acc = psel && penable;
  wire [7:0] idx = paddr[9:2];
  // Cycles since the reset pin was last seen low, saturating
  reg  [2:0] sinceLow_r = 3'h7;

  always @(posedge clk)
    sinceLow_r <= !resetPinLow ? 3'h0 : (sinceLow_r == 3'h7) ? 3'h7
                : sinceLow_r + 3'h1;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  serial_drive_a: assert property (directWriteMode |-> serialOutEn)
    else $error("serial output released in write mode");
  nvm_route_a: assert property (
    directWriteMode && acc && pwrite && idx != 8'h00 |=> nvmWrStb)
    else $error("write in memory mode missed the memory port");
  mode_hold_a: assert property (
    !$stable(directWriteMode) |-> sinceLow_r < 3'h7)
    else $error("write mode changed without a reset pin release");
  fb_commit_a: assert property (
    !$stable(feedbackDividerField) |->
      $past(acc && pwrite && idx == 8'h75) || sinceLow_r < 3'h7)
    else $error("feedback divider changed without last byte");
  frac_commit_a: assert property (
    !$stable(fractionalDividerField) |->
      $past(acc && pwrite && idx == 8'h7C) || sinceLow_r < 3'h7)
    else $error("fraction changed without last byte");
  unmapped_err_a: assert property (
    acc && idx == 8'h20 && !directWriteMode |-> pslverr)
    else $error("reserved address not refused");
  upper_zero_a: assert property (
    acc && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("read data wider than a byte");
  bank_path_a: assert property (
    bankSourceSelect[1:0] == `SRC_PATH2 |-> bankClk[0] == path2Clk)
    else $error("bank zero not on second path");
  bank_frac_a: assert property (
    bankSourceSelect[3:2] == `SRC_PLL_FRAC |-> bankClk[1] == pllFracClk)
    else $error("bank one not on fractional divider");
endmodule

bind config_register_bank_path2_select config_bank_checker chkI
(
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
  .resetPinLow(resetPinLow), .serialOutEn(serialOutEn),
  .directWriteMode(directWriteMode), .nvmWrStb(nvmWrStb),
  .pllFracClk(pllFracClk), .path2Clk(path2Clk), .bankClk(bankClk),
  .bankSourceSelect(bankSourceSelect),
  .feedbackDividerField(feedbackDividerField),
  .fractionalDividerField(fractionalDividerField)
);

`default_nettype wire

// >>> bench/config_register_bank_path2_select_tb.sv
// Self-checking bench for the configuration register bank over APB.
// Assumes the memory model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module config_register_bank_path2_select_tb;
  logic        clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        resetPinLow = 1'h1;
  logic        testStrap = 1'h0;
  logic [2:0]  cfgStraps = 3'h5;
  logic [1:0]  ifStraps = 2'h0;
  logic [3:0]  gpioPin = 4'h0;
  logic        bootDone = 1'h1;
  logic [41:0] fbLive = 42'h2AB_CDEF_1234;
  logic [4:0]  refs = 5'h00;
  logic        pllIntClk = 1'h0;
  logic        pllFracClk = 1'h1;
  wire  [31:0] prdata;
  wire         pready, pslverr, soEn, dwm, stb, p2Clk, irq;
  wire  [7:0]  nAddr, nWr, nRd, pinFn;
  wire  [2:0]  selected_reference;
  wire  [5:0]  bankClk;
  wire  [11:0] bankSrc;
  wire  [41:0] fbField;
  wire  [39:0] frField;
  logic [7:0]  rdv;
  logic        rerr;
  int          err_count = 0;
  int          checked = 0;
  int          cyc = 0;
  int          i;

  always #10 clk = ~clk;

  config_register_bank_path2_select dut
  (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .resetPinLow(resetPinLow),
    .testStrap(testStrap), .configSelectStraps(cfgStraps),
    .ifaceSelectStraps(ifStraps), .gpioPin(gpioPin),
    .bootDoneFlag(bootDone), .feedbackDividerLive(fbLive),
    .serialOutReq(1'h0), .serialOutEn(soEn), .directWriteMode(dwm),
    .nvmWrStb(stb), .nvmAddr(nAddr), .nvmWrData(nWr), .nvmRdData(nRd),
    .inputClockOne(refs[0]), .inputClockTwo(refs[1]),
    .inputClockThree(refs[2]), .crystalPinIn(refs[3]),
    .crystalDriverClk(refs[4]), .pllIntClk(pllIntClk),
    .pllFracClk(pllFracClk), .path2Clk(p2Clk), .selectedReference(selected_reference),
    .bankClk(bankClk), .bankSourceSelect(bankSrc),
    .feedbackDividerField(fbField), .fractionalDividerField(frField),
    .pinFunctionReg(pinFn), .interruptReq(irq)
  );

  nvm_model mem
  (
    .clk(clk), .wrStb(stb), .wrAddr(nAddr), .wrData(nWr),
    .rdIdx(paddr[9:2]), .rdData(nRd)
  );

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    begin
      $display("checked %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    begin
      checked++;
      if (got !== exp)
      begin
        err_count++;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask

  // One APB transfer; entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] ix,
                      input logic [7:0] d);
    begin
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {22'h00_0000, ix, 2'h0};
      pwdata <= {24'h00_0000, d};
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1)
        @(posedge clk);
      rdv = prdata[7:0];
      rerr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
    end
  endtask

  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    xfer(1'h1, ix, d);
  endtask

  task automatic rd(input logic [7:0] ix, input logic [7:0] exp);
    begin
      xfer(1'h0, ix, 8'h00);
      chk(rdv, exp);
    end
  endtask

  task automatic pinPulse;
    begin
      resetPinLow <= 1'h0;
      repeat (5) @(posedge clk);
      resetPinLow <= 1'h1;
      repeat (6) @(posedge clk);
    end
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      $display("unexpected at %0t: run did not finish", $time);
      conclude();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    rd(8'h07, 8'h00);
    rd(8'h62, 8'h00);
    chk(fbField, 42'h0);
    rd(8'h43, 8'h80);
    xfer(1'h0, 8'h20, 8'h00);
    chk({rerr, rdv}, 9'h100);
    gpioPin <= 4'hA;
    repeat (5) @(posedge clk);
    rd(8'h41, 8'hAA);
    wr(8'h41, 8'h00);
    rd(8'h41, 8'hAA);
    wr(8'h41, 8'h20);
    rd(8'h41, 8'h8A);
    wr(8'h42, 8'h02);
    wr(8'h43, 8'h88);
    chk(irq, 1'h1);
    rd(8'h42, 8'h03);
    wr(8'h43, 8'h02);
    chk(irq, 1'h0);
    rd(8'h43, 8'h82);
    for (i = 0; i < 5; i++)
      wr(8'h70 + i[7:0], 8'h01 + i[7:0]);
    chk(fbField, 42'h0);
    wr(8'h75, 8'h03);
    chk(fbField, {2'h3, 40'h05_0403_0201});
    rd(8'h72, 8'h03);
    wr(8'h76, 8'h01);
    rd(8'h70, 8'h34);
    wr(8'h76, 8'h00);
    rd(8'h70, 8'h01);
    for (i = 0; i < 4; i++)
      wr(8'h78 + i[7:0], 8'h11 * (i[7:0] + 8'h01));
    chk(frField, 40'h0);
    wr(8'h7C, 8'h55);
    chk(frField, 40'h55_4433_2211);
    for (i = 0; i < 5; i++)
    begin
      refs <= 5'h01 << i;
      wr(8'h62, i[7:0]);
      chk({selected_reference, p2Clk}, {i[2:0], 1'h1});
    end
    wr(8'h60, 8'h02);
    wr(8'h62, 8'h91);
    chk(selected_reference, 3'h1);
    gpioPin <= 4'hE;
    repeat (5) @(posedge clk);
    chk(selected_reference, 3'h2);
    rd(8'h49, 8'h02);
    wr(8'h49, 8'h07);
    rd(8'h49, 8'h02);
    refs <= 5'h04;
    pllIntClk <= 1'h1;
    wr(8'h07, 8'h06);
    chk({bankSrc[5:0], bankClk[2:0]}, {6'h06, 3'h7});
    refs <= 5'h00;
    pllIntClk <= 1'h0;
    @(posedge clk);
    chk(bankClk[2:0], 3'h2);
    wr(8'h0D, 8'h1F);
    wr(8'h0B, 8'h04);
    chk(pinFn, 8'h04);
    wr(8'h00, 8'h80);
    wr(8'h05, 8'h5A);
    rd(8'h05, 8'h5A);
    wr(8'h00, 8'h00);
    rd(8'h07, 8'h06);
    {testStrap, cfgStraps, ifStraps} <= 6'h23;
    pinPulse();
    chk({dwm, soEn, bankSrc}, 14'h3000);
    wr(8'h62, 8'h03);
    chk(selected_reference, 3'h0);
    rd(8'h62, 8'h03);
    pinPulse();
    chk({dwm, soEn}, 2'h0);
    rd(8'h62, 8'h00);
    conclude();
  end
endmodule

`default_nettype wire
